/* fle_pkg.sv */
// package: opcodes, flag positions, pointer selects and cycle counts
// Contract
// - set half carry: h=1, one cycle
// - clear half carry: h=0, one cycle
// - set overflow: v=1, one cycle
// - bit store copies register bit to t
// - pre-decrement load: ptr-1, then read, two cycles
// - post-increment load: read, then ptr+1, two cycles
// - displacement load reads ptr+q, pointer kept
package fle_pkg;
    // status flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    // operation codes presented by the decode path
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_SET_HALF_CARRY = 3'b001,
        OP_CLEAR_HALF_CARRY = 3'b010,
        OP_SET_OVERFLOW = 3'b011,
        OP_BIT_TO_TRANSFER = 3'b100,
        OP_LOAD_PLAIN = 3'b101,
        OP_LOAD_POST_INC = 3'b110,
        OP_LOAD_PRE_DEC = 3'b111
    } fle_op_t;
    // displacement load is plain load with q != 0; kept as one code
    // pointer selects
    localparam logic [1:0] PTR_X = 2'h0;
    localparam logic [1:0] PTR_Y = 2'h1;
    localparam logic [1:0] PTR_Z = 2'h2;
    localparam logic [15:0] PTR_RESET = 16'h0000;
    // cycle counts
    localparam int FLAG_OP_CYCLES = 1;
    localparam int LOAD_CYCLES = 2;
endpackage : fle_pkg

/* fle_ptr_bank.sv */
// pointer register bank: three 16-bit pointers with one write port
`timescale 1ns/1ps
module fle_ptr_bank #(
    parameter int PW = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // read select and data, registered
    input wire logic [1:0] rd_sel,
    output logic [PW-1:0] rd_data,
    // write port
    input wire logic wr_en,
    input wire logic [1:0] wr_sel,
    input wire logic [PW-1:0] wr_data
);
    logic [PW-1:0] ptr_q [3];
    logic [PW-1:0] rd_q;

    // one update per pointer, reset to zero
    for (genvar i = 0; i < 3; i++) begin : g_ptr
        always_ff @(posedge clk)
        begin
            if (rst)
                ptr_q[i] <= fle_pkg::PTR_RESET;
            else if (wr_en && wr_sel == 2'(i))
                ptr_q[i] <= wr_data;
        end
    end

    // registered read; write bypass keeps the new value visible
    always_ff @(posedge clk)
    begin
        if (rst)
            rd_q <= fle_pkg::PTR_RESET;
        else if (wr_en && wr_sel == rd_sel)
            rd_q <= wr_data;
        else
            rd_q <= (rd_sel < 2'h3) ? ptr_q[rd_sel] : fle_pkg::PTR_RESET;
    end
    assign rd_data = rd_q;
endmodule : fle_ptr_bank

/* fle_exec.sv */
// execution unit for flag set/clear, bit store and indirect loads
`timescale 1ns/1ps
module fle_exec #(
    parameter int PW = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // decoded instruction
    input wire logic op_valid,
    input wire fle_pkg::fle_op_t op_code,
    input wire logic [4:0] op_dst,
    input wire logic [2:0] op_bit,
    input wire logic [7:0] op_src_data,
    input wire logic [1:0] op_ptr,
    input wire logic [5:0] op_disp,
    output logic op_ready,
    // data memory read
    output logic mem_rd_en,
    output logic [PW-1:0] mem_addr,
    input wire logic [7:0] mem_rd_data,
    // register file write
    output logic rf_wr_en,
    output logic [4:0] rf_wr_addr,
    output logic [7:0] rf_wr_data,
    // status flags
    output logic [7:0] status_flags_register
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_DATA = 2'b10
    } fle_state_t;

    fle_state_t state_q, state_d;
    logic [7:0] flags_q, flags_d;
    logic mem_rd_q, rf_wr_q, ready_q;
    logic [PW-1:0] addr_q;
    logic [4:0] dst_q, rfa_q;
    logic [7:0] rfd_q;
    logic [1:0] sel_q;
    logic [5:0] disp_q;
    fle_pkg::fle_op_t code_q;
    logic [PW-1:0] ptr_val;
    logic ptr_wr;
    logic [PW-1:0] ptr_new;
    logic [PW-1:0] eff_addr;
    logic take;
    logic is_load;
    logic [1:0] ptr_rd_sel;

    // read the requested pointer on acceptance, the captured one after
    assign ptr_rd_sel = take ? op_ptr : sel_q;

    fle_ptr_bank #(.PW(PW)) fle_ptr_bank_i (
        .clk(clk),
        .rst(rst),
        .rd_sel(ptr_rd_sel),
        .rd_data(ptr_val),
        .wr_en(ptr_wr),
        .wr_sel(sel_q),
        .wr_data(ptr_new)
    );

    // decode of the incoming request
    assign take = op_valid && state_q == ST_IDLE;
    assign is_load = op_code == fle_pkg::OP_LOAD_PLAIN
        || op_code == fle_pkg::OP_LOAD_POST_INC
        || op_code == fle_pkg::OP_LOAD_PRE_DEC;

    // address: pre-decrement or pointer plus q
    assign eff_addr = (code_q == fle_pkg::OP_LOAD_PRE_DEC)
        ? PW'(ptr_val - 1'b1)
        : PW'(ptr_val + {{(PW-6){1'b0}}, disp_q});
    assign ptr_new = (code_q == fle_pkg::OP_LOAD_PRE_DEC)
        ? PW'(ptr_val - 1'b1) : PW'(ptr_val + 1'b1);
    // pointer written back during the address cycle
    assign ptr_wr = state_q == ST_ADDR
        && (code_q == fle_pkg::OP_LOAD_PRE_DEC
        || code_q == fle_pkg::OP_LOAD_POST_INC);

    // flag and next-state logic
    always_comb
    begin
        flags_d = flags_q;
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:
            begin
                if (take)
                begin
                    unique case (op_code)
                        fle_pkg::OP_SET_HALF_CARRY:
                            flags_d[fle_pkg::FLAG_H] = 1'b1;
                        fle_pkg::OP_CLEAR_HALF_CARRY:
                            flags_d[fle_pkg::FLAG_H] = 1'b0;
                        fle_pkg::OP_SET_OVERFLOW:
                            flags_d[fle_pkg::FLAG_V] = 1'b1;
                        fle_pkg::OP_BIT_TO_TRANSFER:
                            flags_d[fle_pkg::FLAG_T] = op_src_data[op_bit];
                        fle_pkg::OP_LOAD_PLAIN,
                        fle_pkg::OP_LOAD_POST_INC,
                        fle_pkg::OP_LOAD_PRE_DEC:
                            state_d = ST_ADDR;
                        fle_pkg::OP_NONE:
                            state_d = ST_IDLE;
                    endcase
                end
            end
            ST_ADDR: state_d = ST_DATA;
            ST_DATA: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    // state and flags; loads never touch flags
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            flags_q <= fle_pkg::FLAGS_RESET;
        end
        else
        begin
            state_q <= state_d;
            flags_q <= flags_d;
        end
    end

    // capture of load operands on acceptance
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            code_q <= fle_pkg::OP_NONE;
            sel_q <= fle_pkg::PTR_X;
            dst_q <= 5'h00;
            disp_q <= 6'h00;
        end
        else if (take && is_load)
        begin
            code_q <= op_code;
            sel_q <= op_ptr;
            dst_q <= op_dst;
            // post-inc and pre-dec carry no displacement
            disp_q <= (op_code == fle_pkg::OP_LOAD_PLAIN) ? op_disp : 6'h00;
        end
    end

    // memory request in the data cycle, write-back in the idle cycle after it
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mem_rd_q <= 1'b0;
            addr_q <= fle_pkg::PTR_RESET;
            rf_wr_q <= 1'b0;
            rfa_q <= 5'h00;
            rfd_q <= 8'h00;
            ready_q <= 1'b1;
        end
        else
        begin
            mem_rd_q <= state_q == ST_ADDR;
            if (state_q == ST_ADDR)
                addr_q <= eff_addr;
            rf_wr_q <= state_q == ST_DATA;
            rfa_q <= dst_q;
            rfd_q <= mem_rd_data;
            ready_q <= state_d == ST_IDLE;
        end
    end

    assign op_ready = ready_q;
    assign mem_rd_en = mem_rd_q;
    assign mem_addr = addr_q;
    assign rf_wr_en = rf_wr_q;
    assign rf_wr_addr = rfa_q;
    assign rf_wr_data = rfd_q;
    assign status_flags_register = flags_q;

    // flag ops change exactly one bit in one cycle
    property p_half_set;
        @(posedge clk) disable iff (rst)
        take && op_code == fle_pkg::OP_SET_HALF_CARRY |=>
            flags_q[fle_pkg::FLAG_H] && flags_q[4:0] == $past(flags_q[4:0])
            && flags_q[7:6] == $past(flags_q[7:6]);
    endproperty
    a_half_set: assert property (p_half_set) else $error("h not set");
    property p_half_clr;
        @(posedge clk) disable iff (rst)
        take && op_code == fle_pkg::OP_CLEAR_HALF_CARRY |=>
            !flags_q[fle_pkg::FLAG_H] && flags_q[7:6] == $past(flags_q[7:6])
            && flags_q[4:0] == $past(flags_q[4:0]);
    endproperty
    a_half_clr: assert property (p_half_clr) else $error("h not clr");
    property p_ovf_set;
        @(posedge clk) disable iff (rst)
        take && op_code == fle_pkg::OP_SET_OVERFLOW |=>
            flags_q[fle_pkg::FLAG_V] && flags_q[7:4] == $past(flags_q[7:4])
            && flags_q[2:0] == $past(flags_q[2:0]);
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("v not set");
    property p_bst;
        @(posedge clk) disable iff (rst)
        take && op_code == fle_pkg::OP_BIT_TO_TRANSFER |=>
            flags_q[fle_pkg::FLAG_T] == $past(op_src_data[op_bit])
            && flags_q[5:0] == $past(flags_q[5:0])
            && flags_q[7] == $past(flags_q[7]);
    endproperty
    a_bst: assert property (p_bst) else $error("t not copied");
    property p_load_len;
        @(posedge clk) disable iff (rst)
        take && is_load |=> state_q == ST_ADDR ##1 state_q == ST_DATA
            ##1 state_q == ST_IDLE && rf_wr_en;
    endproperty
    a_load_len: assert property (p_load_len) else $error("load length");
    property p_load_flags;
        @(posedge clk) disable iff (rst)
        state_q != ST_IDLE |=> $stable(flags_q);
    endproperty
    a_load_flags: assert property (p_load_flags) else $error("flags moved");
    property p_disp;
        @(posedge clk) disable iff (rst)
        state_q == ST_ADDR && code_q == fle_pkg::OP_LOAD_PLAIN |=>
            mem_addr == PW'($past(ptr_val) + {{(PW-6){1'b0}}, $past(disp_q)});
    endproperty
    a_disp: assert property (p_disp) else $error("bad disp addr");
    property p_wrap;
        @(posedge clk) disable iff (rst)
        ptr_wr && code_q == fle_pkg::OP_LOAD_POST_INC && ptr_val == '1
            |-> ptr_new == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap");
endmodule : fle_exec

/* fle_mem_model.sv */
// data memory partner: one byte per address, answers the read strobe
`timescale 1ns/1ps
module fle_mem_model (
    // clock
    clk,
    // read port
    mem_rd_en,
    mem_addr,
    mem_rd_data
);
    input wire logic clk;
    input wire logic mem_rd_en;
    input wire logic [15:0] mem_addr;
    output logic [7:0] mem_rd_data;
    logic rd_q = 1'b0;
    logic [15:0] addr_q = 16'h0000;
    logic [7:0] junk_q = 8'h00;
    // keep the strobed address one more cycle; the pattern never idles
    always_ff @(posedge clk)
    begin
        rd_q <= mem_rd_en;
        addr_q <= mem_rd_en ? mem_addr : addr_q;
        junk_q <= junk_q + 8'h3b;
    end
    // the strobed data holds one cycle after the strobe; after that the bus moves, so older data cannot match
    assign mem_rd_data = mem_rd_en ? (mem_addr[7:0] ^ mem_addr[15:8] ^ 8'ha5)
        : rd_q ? (addr_q[7:0] ^ addr_q[15:8] ^ 8'ha5) : junk_q;
endmodule : fle_mem_model

/* fle_exec_tb.sv */
// self-checking testbench for the flag and indirect load unit
`timescale 1ns/1ps
module fle_exec_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic op_valid = 1'b0;
    fle_pkg::fle_op_t op_code = fle_pkg::OP_NONE;
    logic [4:0] op_dst = 5'h00;
    logic [2:0] op_bit = 3'h0;
    logic [7:0] op_src_data = 8'h00;
    logic [1:0] op_ptr = 2'h0;
    logic [5:0] op_disp = 6'h00;
    logic op_ready, mem_rd_en, rf_wr_en;
    logic [15:0] mem_addr;
    logic [7:0] mem_rd_data, rf_wr_data, status_flags_register;
    logic [7:0] exp_f = 8'h00;
    logic [4:0] rf_wr_addr;
    int miscompares = 0;
    int n_compared = 0;
    // 20 MHz clock
    always #25 clk = ~clk;
    fle_exec fle_exec_i (.clk(clk), .rst(rst), .op_valid(op_valid),
        .op_code(op_code), .op_dst(op_dst), .op_bit(op_bit),
        .op_src_data(op_src_data), .op_ptr(op_ptr), .op_disp(op_disp),
        .op_ready(op_ready), .mem_rd_en(mem_rd_en), .mem_addr(mem_addr),
        .mem_rd_data(mem_rd_data), .rf_wr_en(rf_wr_en),
        .rf_wr_addr(rf_wr_addr), .rf_wr_data(rf_wr_data),
        .status_flags_register(status_flags_register));
    fle_mem_model fle_mem_model_i (.clk(clk), .mem_rd_en(mem_rd_en),
        .mem_addr(mem_addr), .mem_rd_data(mem_rd_data));
    // verdict and end of run
    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // wait for idle mid-cycle, then hold one request over one rising edge
    task automatic issue(input fle_pkg::fle_op_t op, input logic [2:0] b,
        input logic [7:0] src, input logic [1:0] p, input logic [5:0] q);
        int i;
        for (i = 0; i < 20 && op_ready !== 1'b1; i++)
            @(negedge clk);
        if (i == 20)
        begin
            miscompares++;
            results();
        end
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= op;
        op_dst <= {2'h0, b} + 5'h10;
        op_bit <= b;
        op_src_data <= src;
        op_ptr <= p;
        op_disp <= q;
        // taken at this edge; results are looked at half a cycle later
        @(posedge clk);
        op_valid <= 1'b0;
        @(negedge clk);
    endtask : issue
    // one load: n counts cycles after the take edge; strobe 2, write 3
    task automatic load(input fle_pkg::fle_op_t op, input logic [1:0] p,
        input logic [5:0] q, input logic [15:0] a);
        int seen;
        seen = 0;
        issue(op, 3'h5, 8'h00, p, q);
        for (int n = 1; n < 8; n++)
        begin
            if (n == 1)
                chk({15'h0, op_ready}, 16'h0000);
            if (mem_rd_en === 1'b1)
            begin
                seen++;
                chk(16'(n), 16'h2);
                chk(mem_addr, a);
            end
            if (rf_wr_en === 1'b1)
            begin
                chk(16'(n), 16'h3);
                chk(16'(seen), 16'h1);
                chk({11'h0, rf_wr_addr}, 16'h15);
                chk({8'h0, rf_wr_data}, {8'h0, a[7:0] ^ a[15:8] ^ 8'ha5});
                chk({8'h0, status_flags_register}, {8'h0, exp_f});
                chk({15'h0, op_ready}, 16'h0001);
                return;
            end
            @(negedge clk);
        end
        miscompares++;
        results();
    endtask : load
    task automatic t_flags();
        chk({8'h0, status_flags_register}, 16'h0000);
        exp_f[fle_pkg::FLAG_H] = 1'b1;
        issue(fle_pkg::OP_SET_HALF_CARRY, 3'h0, 8'h00, 2'h0, 6'h00);
        chk({8'h0, status_flags_register}, {8'h0, exp_f});
        exp_f[fle_pkg::FLAG_V] = 1'b1;
        issue(fle_pkg::OP_SET_OVERFLOW, 3'h0, 8'h00, 2'h0, 6'h00);
        chk({8'h0, status_flags_register}, {8'h0, exp_f});
        exp_f[fle_pkg::FLAG_H] = 1'b0;
        issue(fle_pkg::OP_CLEAR_HALF_CARRY, 3'h0, 8'h00, 2'h0, 6'h00);
        chk({8'h0, status_flags_register}, {8'h0, exp_f});
        $display("test flags done");
    endtask : t_flags
    // every bit position, alternating the copied value
    task automatic t_bit_store();
        logic [7:0] m;
        for (int b = 0; b < 8; b++)
        begin
            m = 8'h01 << b;
            exp_f[fle_pkg::FLAG_T] = b[0];
            issue(fle_pkg::OP_BIT_TO_TRANSFER, 3'(b), b[0] ? m : ~m, 2'h0,
                6'h00);
            chk({8'h0, status_flags_register}, {8'h0, exp_f});
        end
        $display("test bit store done");
    endtask : t_bit_store
    // pointers start at zero, so the first decrement wraps
    task automatic t_loads();
        load(fle_pkg::OP_LOAD_PRE_DEC, fle_pkg::PTR_X, 6'h00,
            16'hffff);
        load(fle_pkg::OP_LOAD_POST_INC, fle_pkg::PTR_X, 6'h00,
            16'hffff);
        load(fle_pkg::OP_LOAD_PLAIN, fle_pkg::PTR_X, 6'h00,
            16'h0000);
        load(fle_pkg::OP_LOAD_PLAIN, fle_pkg::PTR_Y, 6'h3f,
            16'h003f);
        load(fle_pkg::OP_LOAD_PLAIN, fle_pkg::PTR_Y, 6'h00,
            16'h0000);
        load(fle_pkg::OP_LOAD_POST_INC, fle_pkg::PTR_Z, 6'h00,
            16'h0000);
        load(fle_pkg::OP_LOAD_PRE_DEC, fle_pkg::PTR_Z, 6'h00,
            16'h0000);
        $display("test loads done");
    endtask : t_loads
    // a flag request held high while a load runs must be refused
    task automatic t_busy();
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= fle_pkg::OP_LOAD_PLAIN;
        op_ptr <= fle_pkg::PTR_Y;
        op_disp <= 6'h00;
        // load taken here; the flag op then waits through the busy cycles
        @(posedge clk);
        op_code <= fle_pkg::OP_SET_HALF_CARRY;
        repeat (2) @(posedge clk);
        op_valid <= 1'b0;
        @(negedge clk);
        chk({15'h0, rf_wr_en}, 16'h0001);
        chk({8'h0, rf_wr_data}, 16'h00a5);
        chk({8'h0, status_flags_register}, {8'h0, exp_f});
        $display("test busy done");
    endtask : t_busy
    // main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        t_flags();
        t_bit_store();
        t_loads();
        t_busy();
        results();
    end
endmodule : fle_exec_tb
